// >>> hdl/bbfe_core.sv
// Function
// - Branch: one clock skipped, two taken
// - Lower branch taken when carry set
// - Negative branch taken when N set
// - Positive branch taken when N clear
// - Signed branches test N xor V
// - Half-carry branches test H flag
// - Transfer branches test T flag
// - Overflow branch taken when V set
// - I/O bit set, two clocks, flags kept
// - I/O bit clear, two clocks, flags kept
// - Logical shift up, zero in, flags
// - Logical shift down, zero in bit7
// - Rotate up through carry, one clock
// - Rotate down through carry, one clock
// - Arithmetic shift down keeps bit 7
// - Flag raise/drop touches only chosen bit
// - Register bit copied into T flag
// - T flag copied into register bit
// - Dedicated C,N,Z,V,I set and clear
// - Dedicated S,T,H set and clear
module bbfe_core (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Execution status
    output logic busy
);

    // ************************************************************
    // State
    // ************************************************************
    bbfe_pkg::bbfe_state_t state;
    logic [31:0] instr;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [7:0] wreg;
    logic [7:0] ioReg [bbfe_pkg::IO_REGS];
    logic lastTaken;
    logic dPend;
    logic dWrite;
    logic [7:0] dAddr;
    logic wasBusy;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // ************************************************************
    // Decode
    // ************************************************************
    bbfe_pkg::bbfe_op_t op;
    logic [2:0] bitSel;
    logic [7:0] offs;
    logic [1:0] ioSel;
    logic isBranch;
    logic branchHit;
    logic [15:0] targetPc;
    logic twoCycle;
    logic commit;

    function automatic logic branchCond(input bbfe_pkg::bbfe_op_t o, input logic [7:0] f);
        case (o)
            bbfe_pkg::OP_JUMP_IF_LOWER: branchCond = f[bbfe_pkg::FLAG_C];
            bbfe_pkg::OP_JUMP_IF_NEGATIVE: branchCond = f[bbfe_pkg::FLAG_N];
            bbfe_pkg::OP_JUMP_IF_POSITIVE: branchCond = !f[bbfe_pkg::FLAG_N];
            bbfe_pkg::OP_JUMP_IF_SIGNED_GE: branchCond = !(f[bbfe_pkg::FLAG_N] ^ f[bbfe_pkg::FLAG_V]);
            bbfe_pkg::OP_JUMP_IF_SIGNED_LT: branchCond = f[bbfe_pkg::FLAG_N] ^ f[bbfe_pkg::FLAG_V];
            bbfe_pkg::OP_JUMP_IF_HALFCARRY_SET: branchCond = f[bbfe_pkg::FLAG_H];
            bbfe_pkg::OP_JUMP_IF_HALFCARRY_CLEAR: branchCond = !f[bbfe_pkg::FLAG_H];
            bbfe_pkg::OP_JUMP_IF_TRANSFER_SET: branchCond = f[bbfe_pkg::FLAG_T];
            bbfe_pkg::OP_JUMP_IF_TRANSFER_CLEAR: branchCond = !f[bbfe_pkg::FLAG_T];
            bbfe_pkg::OP_JUMP_IF_OVERFLOW: branchCond = f[bbfe_pkg::FLAG_V];
            default: branchCond = 1'h0;
        endcase
    endfunction : branchCond

    assign op = bbfe_pkg::bbfe_op_t'(instr[bbfe_pkg::OP_MSB:bbfe_pkg::OP_LSB]);
    assign bitSel = instr[bbfe_pkg::BIT_MSB:bbfe_pkg::BIT_LSB];
    assign offs = instr[bbfe_pkg::OFS_MSB:bbfe_pkg::OFS_LSB];
    assign ioSel = instr[bbfe_pkg::IOS_MSB:bbfe_pkg::OFS_LSB];
    assign isBranch = (op >= bbfe_pkg::OP_JUMP_IF_LOWER) && (op <= bbfe_pkg::OP_JUMP_IF_OVERFLOW);
    assign branchHit = isBranch && branchCond(op, flags);
    assign targetPc = pc + {{8{offs[7]}}, offs} + bbfe_pkg::PC_STEP;
    assign twoCycle = branchHit || (op == bbfe_pkg::OP_IO_BIT_WRITE_ONE)
        || (op == bbfe_pkg::OP_IO_BIT_WRITE_ZERO);
    assign commit = ((state == bbfe_pkg::S_EXEC) && !twoCycle) || (state == bbfe_pkg::S_SECOND);

    // ************************************************************
    // Shifter
    // ************************************************************
    logic isShift;
    logic shiftUp;
    logic [7:0] shRes;
    logic shC;
    logic shN;
    logic [7:0] shFlags;

    assign isShift = (op >= bbfe_pkg::OP_LOGICAL_SHIFT_UP) && (op <= bbfe_pkg::OP_ARITH_SHIFT_DOWN);
    assign shiftUp = (op == bbfe_pkg::OP_LOGICAL_SHIFT_UP) || (op == bbfe_pkg::OP_CARRY_ROTATE_UP);
    assign shRes = (op == bbfe_pkg::OP_LOGICAL_SHIFT_UP) ? {wreg[6:0], 1'h0}
        : (op == bbfe_pkg::OP_LOGICAL_SHIFT_DOWN) ? {1'h0, wreg[7:1]}
        : (op == bbfe_pkg::OP_CARRY_ROTATE_UP) ? {wreg[6:0], flags[bbfe_pkg::FLAG_C]}
        : (op == bbfe_pkg::OP_CARRY_ROTATE_DOWN) ? {flags[bbfe_pkg::FLAG_C], wreg[7:1]}
        : {wreg[7], wreg[7:1]};
    // bit 7 or bit 0 leaves into carry
    assign shC = shiftUp ? wreg[7] : wreg[0];
    assign shN = shRes[7];
    // Only Z, C, N and V move; S, H, T and I hold
    assign shFlags = {flags[7:4], shN ^ shC, shN, shRes == 8'h00, shC};

    // ************************************************************
    // Flag operations
    // ************************************************************
    logic isDedicated;
    logic isFlagOp;
    logic [2:0] fBit;
    logic fVal;
    logic [7:0] flagMask;

    function automatic logic [2:0] dedBit(input bbfe_pkg::bbfe_op_t o);
        case (o)
            bbfe_pkg::OP_CARRY_RAISE, bbfe_pkg::OP_CARRY_DROP: dedBit = bbfe_pkg::FLAG_C;
            bbfe_pkg::OP_NEG_RAISE, bbfe_pkg::OP_NEG_DROP: dedBit = bbfe_pkg::FLAG_N;
            bbfe_pkg::OP_ZERO_RAISE, bbfe_pkg::OP_ZERO_DROP: dedBit = bbfe_pkg::FLAG_Z;
            bbfe_pkg::OP_OVF_RAISE, bbfe_pkg::OP_OVF_DROP: dedBit = bbfe_pkg::FLAG_V;
            bbfe_pkg::OP_IRQ_GLOBAL_ON, bbfe_pkg::OP_IRQ_GLOBAL_OFF: dedBit = bbfe_pkg::FLAG_I;
            bbfe_pkg::OP_SIGN_RAISE, bbfe_pkg::OP_SIGN_DROP: dedBit = bbfe_pkg::FLAG_S;
            bbfe_pkg::OP_TRANSFER_RAISE, bbfe_pkg::OP_TRANSFER_DROP: dedBit = bbfe_pkg::FLAG_T;
            default: dedBit = bbfe_pkg::FLAG_H;
        endcase
    endfunction : dedBit

    assign isDedicated = (op >= bbfe_pkg::OP_CARRY_RAISE) && (op <= bbfe_pkg::OP_HALF_DROP);
    assign isFlagOp = isDedicated || (op == bbfe_pkg::OP_FLAG_BIT_RAISE)
        || (op == bbfe_pkg::OP_FLAG_BIT_DROP);
    // same path for S, T and H
    assign fBit = isDedicated ? dedBit(op) : bitSel;
    // Dedicated raise codes are even, drop codes odd
    assign fVal = (op == bbfe_pkg::OP_FLAG_BIT_RAISE) || (isDedicated && !op[0]);
    assign flagMask = 8'h01 << fBit;

    // ************************************************************
    // Next architectural values
    // ************************************************************
    logic [7:0] next_flags;
    logic [7:0] next_wreg;
    logic [15:0] next_pc;

    always_comb begin
        next_flags = flags;
        next_wreg = wreg;
        next_pc = pc + bbfe_pkg::PC_STEP;
        if (branchHit) begin
            next_pc = targetPc;
        end
        // shifts update Z, C, N, V
        if (isShift) begin
            next_wreg = shRes;
            next_flags = shFlags;
        end
        if (isFlagOp) begin
            next_flags = fVal ? (flags | flagMask) : (flags & ~flagMask);
        end
        if (op == bbfe_pkg::OP_REG_BIT_TO_TRANSFER) begin
            next_flags[bbfe_pkg::FLAG_T] = wreg[bitSel];
        end
        if (op == bbfe_pkg::OP_TRANSFER_TO_REG_BIT) begin
            next_wreg[bitSel] = flags[bbfe_pkg::FLAG_T];
        end
    end

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic addrOk;
    logic busWr;
    logic launch;

    function automatic logic [31:0] readMux(input logic [7:0] a);
        readMux = 32'h0000_0000;
        if (a == bbfe_pkg::OFF_INSTR) begin
            readMux = instr;
        end else if (a == bbfe_pkg::OFF_FLAGS) begin
            readMux = {24'h00_0000, flags};
        end else if (a == bbfe_pkg::OFF_PC) begin
            readMux = {16'h0000, pc};
        end else if (a == bbfe_pkg::OFF_WREG) begin
            readMux = {24'h00_0000, wreg};
        end else if (a == bbfe_pkg::OFF_STAT) begin
            readMux = {30'h0000_0000, lastTaken, busy};
        end else if ((a[7:4] == bbfe_pkg::IO_PAGE) && (a[1:0] == 2'h0)) begin
            readMux = {24'h00_0000, ioReg[a[3:2]]};
        end
    endfunction : readMux

    assign busy = (state != bbfe_pkg::S_IDLE);
    assign hresp = 1'h0;
    // Extra stall cycle after a commit lets hrdata pick up the new state
    assign hreadyout = !(dPend && (busy || wasBusy));
    assign addrOk = hsel && hready && htrans[1] && (hsize == bbfe_pkg::HSIZE_WORD);
    assign busWr = dPend && dWrite && hreadyout;
    assign launch = busWr && (dAddr == bbfe_pkg::OFF_INSTR);

    always_ff @(posedge clock) begin
        if (srst) begin
            dPend <= 1'h0;
            dWrite <= 1'h0;
            dAddr <= 8'h00;
        end else if (hready) begin
            dPend <= addrOk;
            dWrite <= hwrite;
            dAddr <= haddr[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            hrdata <= 32'h0000_0000;
        end else if (addrOk && !hwrite) begin
            hrdata <= readMux(haddr[7:0]);
        end else if (dPend && !dWrite && !hreadyout) begin
            hrdata <= readMux(dAddr);
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= bbfe_pkg::S_IDLE;
            wasBusy <= 1'h0;
        end else begin
            wasBusy <= busy;
            case (state)
                bbfe_pkg::S_IDLE: state <= launch ? bbfe_pkg::S_EXEC : bbfe_pkg::S_IDLE;
                bbfe_pkg::S_EXEC: state <= twoCycle ? bbfe_pkg::S_SECOND : bbfe_pkg::S_IDLE;
                bbfe_pkg::S_SECOND: state <= bbfe_pkg::S_IDLE;
                default: state <= bbfe_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            instr <= bbfe_pkg::INSTR_RST;
            lastTaken <= 1'h0;
        end else if (launch) begin
            instr <= hwdata;
        end else if (state == bbfe_pkg::S_EXEC) begin
            lastTaken <= branchHit;
        end
    end

    // Commit and bus writes never meet: writes stall while busy
    always_ff @(posedge clock) begin
        if (srst) begin
            flags <= bbfe_pkg::FLAGS_RST;
            wreg <= bbfe_pkg::WREG_RST;
            pc <= bbfe_pkg::PC_RST;
        end else if (commit) begin
            flags <= next_flags;
            wreg <= next_wreg;
            pc <= next_pc;
        end else if (busWr) begin
            if (dAddr == bbfe_pkg::OFF_FLAGS) begin
                flags <= hwdata[7:0];
            end
            if (dAddr == bbfe_pkg::OFF_WREG) begin
                wreg <= hwdata[7:0];
            end
            if (dAddr == bbfe_pkg::OFF_PC) begin
                pc <= hwdata[15:0];
            end
        end
    end

    // ************************************************************
    // I/O registers
    // ************************************************************
    for (genvar i = 0; i < bbfe_pkg::IO_REGS; i++) begin : gIo
        logic hitBus;
        logic hitExec;
        assign hitBus = busWr && (dAddr[7:4] == bbfe_pkg::IO_PAGE) && (dAddr[3:2] == 2'(i))
            && (dAddr[1:0] == 2'h0);
        assign hitExec = (state == bbfe_pkg::S_SECOND) && !isBranch && (ioSel == 2'(i));
        always_ff @(posedge clock) begin
            if (srst) begin
                ioReg[i] <= bbfe_pkg::IO_RST;
            end else if (hitExec) begin
                ioReg[i][bitSel] <= (op == bbfe_pkg::OP_IO_BIT_WRITE_ONE);
            end else if (hitBus) begin
                ioReg[i] <= hwdata[7:0];
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence brLaunch;
        (state == bbfe_pkg::S_EXEC) && branchHit;
    endsequence
    sequence ioLaunch;
        (state == bbfe_pkg::S_EXEC)
            && ((op == bbfe_pkg::OP_IO_BIT_WRITE_ONE) || (op == bbfe_pkg::OP_IO_BIT_WRITE_ZERO));
    endsequence
    sequence twoDone;
        (state == bbfe_pkg::S_SECOND) ##1 (state == bbfe_pkg::S_IDLE);
    endsequence

    brTaken_a: assert property (
        brLaunch |=> twoDone ##0 (pc == $past(targetPc, 2)) && (flags == $past(flags, 2)))
        else $error("taken branch target or timing wrong");
    brSkip_a: assert property (
        (state == bbfe_pkg::S_EXEC) && isBranch && !branchHit
            |=> (state == bbfe_pkg::S_IDLE) && (pc == $past(pc) + bbfe_pkg::PC_STEP)
            && (flags == $past(flags)))
        else $error("skipped branch wrong");
    condLower_a: assert property (
        (op == bbfe_pkg::OP_JUMP_IF_LOWER) |-> (branchHit == flags[bbfe_pkg::FLAG_C]))
        else $error("lower branch condition wrong");
    condSign_a: assert property (
        (op == bbfe_pkg::OP_JUMP_IF_SIGNED_LT) || (op == bbfe_pkg::OP_JUMP_IF_SIGNED_GE)
            |-> (branchHit == ((flags[bbfe_pkg::FLAG_N] ^ flags[bbfe_pkg::FLAG_V])
            == (op == bbfe_pkg::OP_JUMP_IF_SIGNED_LT))))
        else $error("signed branch condition wrong");
    ioBit_a: assert property (
        ioLaunch |=> twoDone ##0 (ioReg[ioSel][bitSel] == (op == bbfe_pkg::OP_IO_BIT_WRITE_ONE))
            && (flags == $past(flags, 2)))
        else $error("io bit write wrong");
    shiftUp_a: assert property (
        (state == bbfe_pkg::S_EXEC) && (op == bbfe_pkg::OP_LOGICAL_SHIFT_UP)
            |=> (wreg == {$past(wreg[6:0]), 1'h0}) && (flags[bbfe_pkg::FLAG_C] == $past(wreg[7]))
            && (flags[bbfe_pkg::FLAG_V] == (flags[bbfe_pkg::FLAG_N] ^ flags[bbfe_pkg::FLAG_C])))
        else $error("shift up wrong");
    rotDown_a: assert property (
        (state == bbfe_pkg::S_EXEC) && (op == bbfe_pkg::OP_CARRY_ROTATE_DOWN)
            |=> (wreg == {$past(flags[bbfe_pkg::FLAG_C]), $past(wreg[7:1])})
            && (flags[bbfe_pkg::FLAG_C] == $past(wreg[0])))
        else $error("rotate down wrong");
    arithDown_a: assert property (
        (state == bbfe_pkg::S_EXEC) && (op == bbfe_pkg::OP_ARITH_SHIFT_DOWN)
            |=> (wreg == {$past(wreg[7]), $past(wreg[7:1])})
            && (flags[bbfe_pkg::FLAG_Z] == (wreg == 8'h00)))
        else $error("arithmetic shift wrong");
    flagOnly_a: assert property (
        (state == bbfe_pkg::S_EXEC) && isFlagOp
            |=> (((flags ^ $past(flags)) & ~$past(flagMask)) == 8'h00)
            && ((flags & $past(flagMask)) == ($past(fVal) ? $past(flagMask) : 8'h00)))
        else $error("flag operation wrong");
    bitStore_a: assert property (
        (state == bbfe_pkg::S_EXEC) && (op == bbfe_pkg::OP_REG_BIT_TO_TRANSFER)
            |=> (flags[bbfe_pkg::FLAG_T] == $past(wreg[bitSel])) && (state == bbfe_pkg::S_IDLE))
        else $error("bit store wrong");
    bitLoad_a: assert property (
        (state == bbfe_pkg::S_EXEC) && (op == bbfe_pkg::OP_TRANSFER_TO_REG_BIT)
            |=> (wreg[bitSel] == flags[bbfe_pkg::FLAG_T]) && (flags == $past(flags)))
        else $error("bit load wrong");

endmodule : bbfe_core

// >>> hdl/bbfe_pkg.sv
package bbfe_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_PC = 8'h08;
    localparam logic [7:0] OFF_WREG = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h20;
    // I/O registers sit at 8'h10..8'h1C, one word each
    localparam logic [3:0] IO_PAGE = 4'h1;
    localparam int IO_REGS = 4;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ************************************************************
    // Instruction word fields
    // ************************************************************
    localparam int OP_LSB = 0;
    localparam int OP_MSB = 5;
    localparam int BIT_LSB = 8;
    localparam int BIT_MSB = 10;
    localparam int OFS_LSB = 16;
    localparam int OFS_MSB = 23;
    localparam int IOS_MSB = 17;

    // ************************************************************
    // Flag positions in the processor flag word
    // ************************************************************
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ************************************************************
    // Reset values and steps
    // ************************************************************
    localparam logic [31:0] INSTR_RST = 32'h0000_0000;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [7:0] IO_RST = 8'h00;
    localparam logic [15:0] PC_STEP = 16'h0001;

    // ************************************************************
    // Operations and states
    // ************************************************************
    typedef enum logic [5:0] {
        OP_NOP = 6'h00,
        OP_JUMP_IF_LOWER = 6'h01,
        OP_JUMP_IF_NEGATIVE = 6'h02,
        OP_JUMP_IF_POSITIVE = 6'h03,
        OP_JUMP_IF_SIGNED_GE = 6'h04,
        OP_JUMP_IF_SIGNED_LT = 6'h05,
        OP_JUMP_IF_HALFCARRY_SET = 6'h06,
        OP_JUMP_IF_HALFCARRY_CLEAR = 6'h07,
        OP_JUMP_IF_TRANSFER_SET = 6'h08,
        OP_JUMP_IF_TRANSFER_CLEAR = 6'h09,
        OP_JUMP_IF_OVERFLOW = 6'h0A,
        OP_IO_BIT_WRITE_ONE = 6'h0B,
        OP_IO_BIT_WRITE_ZERO = 6'h0C,
        OP_LOGICAL_SHIFT_UP = 6'h0D,
        OP_LOGICAL_SHIFT_DOWN = 6'h0E,
        OP_CARRY_ROTATE_UP = 6'h0F,
        OP_CARRY_ROTATE_DOWN = 6'h10,
        OP_ARITH_SHIFT_DOWN = 6'h11,
        OP_FLAG_BIT_RAISE = 6'h12,
        OP_FLAG_BIT_DROP = 6'h13,
        OP_REG_BIT_TO_TRANSFER = 6'h14,
        OP_TRANSFER_TO_REG_BIT = 6'h15,
        OP_CARRY_RAISE = 6'h16,
        OP_CARRY_DROP = 6'h17,
        OP_NEG_RAISE = 6'h18,
        OP_NEG_DROP = 6'h19,
        OP_ZERO_RAISE = 6'h1A,
        OP_ZERO_DROP = 6'h1B,
        OP_OVF_RAISE = 6'h1C,
        OP_OVF_DROP = 6'h1D,
        OP_IRQ_GLOBAL_ON = 6'h1E,
        OP_IRQ_GLOBAL_OFF = 6'h1F,
        OP_SIGN_RAISE = 6'h20,
        OP_SIGN_DROP = 6'h21,
        OP_TRANSFER_RAISE = 6'h22,
        OP_TRANSFER_DROP = 6'h23,
        OP_HALF_RAISE = 6'h24,
        OP_HALF_DROP = 6'h25
    } bbfe_op_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_EXEC = 2'b01,
        S_SECOND = 2'b10
    } bbfe_state_t;

endpackage : bbfe_pkg

// >>> tb/branch_bit_flag_exec_bench.sv
module branch_bit_flag_exec_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // Bus signals and reference state
    // ************************************************************
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = bbfe_pkg::HSIZE_WORD;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic busy;
    int failCount = 0;
    int totalChecks = 0;
    logic [31:0] readQ[$];
    int busyQ[$];
    logic rdPhase = 1'b0;
    int busyLen = 0;
    logic [7:0] mFlags = 8'h00;
    logic [7:0] mWreg = 8'h00;
    logic [15:0] mPc = 16'h0000;
    logic [7:0] mIo [4] = '{default: 8'h00};
    // Dedicated flag ops in pairs: C, N, Z, V, I, S, T, H
    logic [2:0] flagPos [8] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h7, 3'h4, 3'h6, 3'h5};

    always #50 clock = ~clock;

    bbfe_core dut (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .busy(busy));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (exp !== got) begin
            failCount++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic endOfTest;
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : endOfTest

    // ************************************************************
    // Monitor: read data and execution length against the notes
    // ************************************************************
    always @(posedge clock) begin
        if (rdPhase && hreadyout === 1'b1) begin
            check("hrdata", readQ.pop_front(), hrdata);
            check("hresp", 32'h0, {31'h0, hresp});
        end
        if (hreadyout === 1'b1) rdPhase <= hsel && htrans == 2'h2 && !hwrite;
        if (busy === 1'b1) busyLen <= busyLen + 1;
        else if (busyLen > 0) begin
            check("busy cycles", busyQ.pop_front(), busyLen);
            busyLen <= 0;
        end
    end

    // No latency assumed: only the watchdog ends a stuck wait
    task automatic waitReady;
        do begin
            @(posedge clock);
        end while (hreadyout !== 1'b1);
    endtask : waitReady

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        waitReady();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        waitReady();
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        readQ.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic zeros;
        for (int a = 0; a <= 'h24; a += 4) rd(8'(a), 32'h0);
    endtask : zeros

    task automatic exec(input logic [5:0] op, input logic [2:0] b, input logic [7:0] k);
        logic [7:0] f;
        logic [7:0] w;
        logic [7:0] r;
        logic t;
        int len;
        f = mFlags;
        w = mWreg;
        r = w;
        t = 1'b0;
        len = 1;
        case (op)
            6'h01: t = f[0];
            6'h02: t = f[2];
            6'h03: t = !f[2];
            6'h04: t = !(f[2] ^ f[3]);
            6'h05: t = f[2] ^ f[3];
            6'h06: t = f[5];
            6'h07: t = !f[5];
            6'h08: t = f[6];
            6'h09: t = !f[6];
            6'h0A: t = f[3];
            6'h0B, 6'h0C: begin
                mIo[k[1:0]][b] = (op == 6'h0B);
                len = 2;
            end
            6'h0D: {f[0], r} = {w, 1'b0};
            6'h0E: {r, f[0]} = {1'b0, w};
            6'h0F: {f[0], r} = {w, f[0]};
            6'h10: {r, f[0]} = {f[0], w};
            6'h11: {r, f[0]} = {w[7], w};
            6'h12, 6'h13: f[b] = (op == 6'h12);
            6'h14: f[6] = w[b];
            6'h15: r[b] = f[6];
            default: if (op >= 6'h16 && op <= 6'h25) f[flagPos[(op - 6'h16) >> 1]] = !op[0];
        endcase
        if (op >= 6'h0D && op <= 6'h11) begin
            f[1] = (r == 8'h00);
            f[2] = r[7];
            f[3] = r[7] ^ f[0];
        end
        if (t) len = 2;
        mPc = t ? mPc + {{8{k[7]}}, k} + 16'h0001 : mPc + 16'h0001;
        mFlags = f;
        mWreg = r;
        busyQ.push_back(len);
        bus(1'b1, bbfe_pkg::OFF_INSTR, {8'h00, k, 5'h00, b, 2'h0, op});
        rd(bbfe_pkg::OFF_FLAGS, {24'h0, f});
        rd(bbfe_pkg::OFF_PC, {16'h0, mPc});
        rd(bbfe_pkg::OFF_WREG, {24'h0, r});
        rd({4'h1, k[1:0], 2'h0}, {24'h0, mIo[k[1:0]]});
        rd(bbfe_pkg::OFF_STAT, {30'h0, t, 1'b0});
    endtask : exec

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] d;
        void'($urandom(43));
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        zeros();
        bus(1'b1, 8'h24, $urandom());
        rd(8'h24, 32'h0);
        // Non-word size is ignored: flags keep their reset value
        hsize <= 3'h0;
        bus(1'b1, bbfe_pkg::OFF_FLAGS, $urandom());
        hsize <= bbfe_pkg::HSIZE_WORD;
        rd(bbfe_pkg::OFF_FLAGS, 32'h0);
        $display("test reset and unmapped done");
        // Every opcode, random flags and operands, three rounds
        for (int rnd = 0; rnd < 3; rnd++) begin
            for (int op = 0; op < 64; op++) begin
                d = $urandom();
                bus(1'b1, bbfe_pkg::OFF_FLAGS, d);
                mFlags = d[7:0];
                d = $urandom();
                bus(1'b1, bbfe_pkg::OFF_WREG, d);
                mWreg = d[7:0];
                d = $urandom();
                bus(1'b1, bbfe_pkg::OFF_PC, d);
                mPc = d[15:0];
                d = $urandom();
                bus(1'b1, {4'h1, d[17:16], 2'h0}, d);
                mIo[d[17:16]] = d[7:0];
                exec(6'(op), d[10:8], d[23:16]);
            end
            $display("test opcode round %0d done", rnd);
        end
        // Reset again in mid-run: everything returns to zero
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        zeros();
        $display("test second reset done");
        endOfTest();
    end

    // Expected run is near 6000 cycles; allow well beyond that
    initial begin
        #5000000;
        failCount++;
        endOfTest();
    end

endmodule : branch_bit_flag_exec_bench
